// ==== src/afps_pkg.sv ====
`default_nettype none
package afps_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int P2_PINS = 6;
	localparam int ISC_W = 6;
	localparam int ADS_W = 3;
	// Register offsets
	localparam logic [3:0] ADDR_ISC = 4'h0;
	localparam logic [3:0] ADDR_P13 = 4'h1;
	localparam logic [3:0] ADDR_PF2 = 4'h2;
	localparam logic [3:0] ADDR_ADPC = 4'h3;
	localparam logic [3:0] ADDR_PM2 = 4'h4;
	localparam logic [3:0] ADDR_P2 = 4'h5;
	localparam logic [3:0] ADDR_ADS = 4'h6;
	localparam logic [3:0] ADDR_CLKM = 4'h7;
	localparam logic [3:0] ADDR_LCD = 4'h8;
	localparam logic [3:0] ADDR_STAT = 4'h9;
	// Input switch control fields
	localparam int ISC_IRQ = 0;
	localparam int ISC_CAP = 1;
	localparam int ISC_GATE = 2;
	localparam int ISC_SEG = 3;
	localparam int ISC_RA = 4;
	localparam int ISC_RB = 5;
	// Port 13 control fields
	localparam int P13_FUNC = 0;
	localparam int P13_MODE = 1;
	localparam int P13_LATCH = 2;
	// Clock operation mode and LCD bias fields
	localparam int CLK_X1 = 0;
	localparam int CLK_EXT = 1;
	localparam int CLK_XT1 = 4;
	localparam int LCD_QUARTER = 0;
	// Reset values
	localparam logic [5:0] ISC_RST = 6'h00;
	localparam logic [2:0] P13_RST = 3'h2;
	localparam logic [5:0] PF2_RST = 6'h00;
	localparam logic [5:0] ADPC_RST = 6'h00;
	localparam logic [5:0] PM2_RST = 6'h3F;
	localparam logic [5:0] P2_RST = 6'h00;
	localparam logic [2:0] ADS_RST = 3'h0;
	localparam logic [7:0] CLKM_RST = 8'h00;
	localparam logic LCD_RST = 1'b0;
	// Synchronised pin vector positions
	localparam int SP_P12 = 0;
	localparam int SP_P13 = 1;
	localparam int SP_P33 = 2;
	localparam int SP_P120 = 3;
	localparam int SP_P113 = 4;
	localparam int SP_P40 = 5;
	localparam int SP_P121 = 6;
	localparam int SP_P122 = 7;
	localparam int SP_N = 8;
endpackage : afps_pkg
`default_nettype wire

// ==== src/afps_pin_select.sv ====
// Notes on behaviour
// - capture bit routes serial-B receive to capture
// - irq bit routes serial-B receive to irq zero
// - gate bit lets 8-bit timer gate counter
// - quarter bias makes key pin LCD reference
// - serial-B on port12/13 only when bit 4 clear and bit 5 set
// - relocation decided only by switch register
// - clock mode resets 00H, oscillator pins inputs
// - debug use turns main oscillator pins debug
// - port2 pin function from four registers
`timescale 1ns/1ps
`default_nettype none
module afps_pin_select #(
	parameter int P2_PINS = afps_pkg::P2_PINS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic pin_p12_in,
	input wire logic pin_p13_in,
	output logic pin_p13_out,
	output logic pin_p13_oe,
	input wire logic pin_p33_in,
	input wire logic pin_p120_in,
	input wire logic pin_p113_in,
	output logic pin_p112_out,
	output logic pin_p112_oe,
	input wire logic pin_p40_in,
	input wire logic pin_p121_in,
	input wire logic pin_p122_in,
	output logic [P2_PINS-1:0] pin_p2_out,
	output logic [P2_PINS-1:0] pin_p2_oe,
	output logic [P2_PINS-1:0] pin_p2_seg_en,
	output logic [P2_PINS-1:0] pin_p2_analog_en,
	output logic [P2_PINS-1:0] adc_channel_active,
	input wire logic [P2_PINS-1:0] lcd_seg_drive,
	input wire logic uart_a_transmit,
	input wire logic uart_b_transmit,
	input wire logic csi_serial_out,
	input wire logic eight_bit_gate_timer,
	input wire logic debug_active,
	output logic uart_b_receive,
	output logic timer_capture_in,
	output logic ext_irq_zero,
	output logic event_counter_enable,
	output logic key_input_four,
	output logic key_input_zero,
	output logic lcd_ref_voltage_four,
	output logic debug_mode_pin_a,
	output logic debug_mode_pin_b,
	output logic main_osc_en,
	output logic external_main_clock_en,
	output logic sub_osc_en
);
	if (P2_PINS < 1 || P2_PINS > afps_pkg::DATA_W)
	begin : g_bad_p2_pins
		$error("P2_PINS must lie in 1..8");
	end

	logic [5:0] input_switch_ctrl_r;
	logic [2:0] p13_ctrl_r;
	logic [P2_PINS-1:0] port2_func_reg_r, adc_port_config_r, port2_mode_reg_r, port2_latch_r;
	logic [2:0] analog_channel_sel_r;
	logic [7:0] clock_op_mode_reg_r;
	logic lcd_quarter_bias_r;
	logic [afps_pkg::SP_N-1:0] raw, s1_r, s2_r, s3_r, pin_f_r;

	// Register writes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			input_switch_ctrl_r <= afps_pkg::ISC_RST;
			p13_ctrl_r <= afps_pkg::P13_RST;
			port2_func_reg_r <= P2_PINS'(afps_pkg::PF2_RST);
			adc_port_config_r <= P2_PINS'(afps_pkg::ADPC_RST);
			port2_mode_reg_r <= P2_PINS'(afps_pkg::PM2_RST);
			port2_latch_r <= P2_PINS'(afps_pkg::P2_RST);
			analog_channel_sel_r <= afps_pkg::ADS_RST;
			clock_op_mode_reg_r <= afps_pkg::CLKM_RST;
			lcd_quarter_bias_r <= afps_pkg::LCD_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				afps_pkg::ADDR_ISC: input_switch_ctrl_r <= reg_wdata[5:0];
				afps_pkg::ADDR_P13: p13_ctrl_r <= reg_wdata[2:0];
				afps_pkg::ADDR_PF2: port2_func_reg_r <= reg_wdata[P2_PINS-1:0];
				afps_pkg::ADDR_ADPC: adc_port_config_r <= reg_wdata[P2_PINS-1:0];
				afps_pkg::ADDR_PM2: port2_mode_reg_r <= reg_wdata[P2_PINS-1:0];
				afps_pkg::ADDR_P2: port2_latch_r <= reg_wdata[P2_PINS-1:0];
				afps_pkg::ADDR_ADS: analog_channel_sel_r <= reg_wdata[2:0];
				afps_pkg::ADDR_CLKM: clock_op_mode_reg_r <= reg_wdata;
				afps_pkg::ADDR_LCD: lcd_quarter_bias_r <= reg_wdata[afps_pkg::LCD_QUARTER];
				default: ;
			endcase
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				afps_pkg::ADDR_ISC: reg_rdata <= {2'h0, input_switch_ctrl_r};
				afps_pkg::ADDR_P13: reg_rdata <= {5'h00, p13_ctrl_r};
				afps_pkg::ADDR_PF2: reg_rdata <= 8'(port2_func_reg_r);
				afps_pkg::ADDR_ADPC: reg_rdata <= 8'(adc_port_config_r);
				afps_pkg::ADDR_PM2: reg_rdata <= 8'(port2_mode_reg_r);
				afps_pkg::ADDR_P2: reg_rdata <= 8'(port2_latch_r);
				afps_pkg::ADDR_ADS: reg_rdata <= {5'h00, analog_channel_sel_r};
				afps_pkg::ADDR_CLKM: reg_rdata <= clock_op_mode_reg_r;
				afps_pkg::ADDR_LCD: reg_rdata <= {7'h00, lcd_quarter_bias_r};
				afps_pkg::ADDR_STAT: reg_rdata <= pin_f_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	assign raw = {pin_p122_in, pin_p121_in, pin_p40_in, pin_p113_in,
		pin_p120_in, pin_p33_in, pin_p13_in, pin_p12_in};

	// Three-stage pin synchroniser with agreement filter
	genvar g;
	generate
		for (g = 0; g < afps_pkg::SP_N; g++)
		begin : g_sync
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					s1_r[g] <= 1'b1;
					s2_r[g] <= 1'b1;
					s3_r[g] <= 1'b1;
					pin_f_r[g] <= 1'b1;
				end
				else
				begin
					s1_r[g] <= raw[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						pin_f_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	logic route_p12, route_p113, rx_b_nxt, p13_nxt, p112_nxt;
	logic [P2_PINS-1:0] p2_analog;
	assign route_p12 = !input_switch_ctrl_r[afps_pkg::ISC_RA]
		&& input_switch_ctrl_r[afps_pkg::ISC_RB];
	assign route_p113 = input_switch_ctrl_r[afps_pkg::ISC_SEG]
		&& !input_switch_ctrl_r[afps_pkg::ISC_RA]
		&& !input_switch_ctrl_r[afps_pkg::ISC_RB];
	// Idle high when no pin carries serial-B receive
	assign rx_b_nxt = route_p12 ? pin_f_r[afps_pkg::SP_P12] :
		route_p113 ? pin_f_r[afps_pkg::SP_P113] : 1'b1;
	// Port13 output: transmit when selected, else clocked serial, ORed with latch
	assign p13_nxt = (p13_ctrl_r[afps_pkg::P13_FUNC] ?
		(route_p12 ? uart_b_transmit : uart_a_transmit) : csi_serial_out)
		| p13_ctrl_r[afps_pkg::P13_LATCH];
	assign p112_nxt = route_p113 ? uart_b_transmit : lcd_seg_drive[0];
	assign p2_analog = ~port2_func_reg_r & adc_port_config_r & port2_mode_reg_r;

	// Peripheral-side routing
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			uart_b_receive <= 1'b1;
			timer_capture_in <= 1'b1;
			ext_irq_zero <= 1'b1;
			event_counter_enable <= 1'b1;
			key_input_four <= 1'b1;
			key_input_zero <= 1'b1;
			lcd_ref_voltage_four <= 1'b0;
			debug_mode_pin_a <= 1'b0;
			debug_mode_pin_b <= 1'b0;
		end
		else
		begin
			uart_b_receive <= rx_b_nxt;
			timer_capture_in <= input_switch_ctrl_r[afps_pkg::ISC_CAP] ?
				rx_b_nxt : pin_f_r[afps_pkg::SP_P33];
			ext_irq_zero <= input_switch_ctrl_r[afps_pkg::ISC_IRQ] ?
				rx_b_nxt : pin_f_r[afps_pkg::SP_P120];
			event_counter_enable <= !input_switch_ctrl_r[afps_pkg::ISC_GATE]
				|| eight_bit_gate_timer;
			key_input_four <= p13_ctrl_r[afps_pkg::P13_FUNC] ? 1'b1 :
				pin_f_r[afps_pkg::SP_P13];
			key_input_zero <= lcd_quarter_bias_r ? 1'b1 : pin_f_r[afps_pkg::SP_P40];
			lcd_ref_voltage_four <= lcd_quarter_bias_r;
			debug_mode_pin_a <= debug_active && pin_f_r[afps_pkg::SP_P121];
			debug_mode_pin_b <= debug_active && pin_f_r[afps_pkg::SP_P122];
		end
	end

	// Pin side and oscillator modes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_p13_out <= 1'b0;
			pin_p13_oe <= 1'b0;
			pin_p112_out <= 1'b0;
			pin_p112_oe <= 1'b0;
			pin_p2_out <= '0;
			pin_p2_oe <= '0;
			pin_p2_seg_en <= '0;
			pin_p2_analog_en <= '0;
			adc_channel_active <= '0;
			main_osc_en <= 1'b0;
			external_main_clock_en <= 1'b0;
			sub_osc_en <= 1'b0;
		end
		else
		begin
			pin_p13_out <= p13_nxt;
			pin_p13_oe <= !p13_ctrl_r[afps_pkg::P13_MODE];
			pin_p112_out <= p112_nxt;
			pin_p112_oe <= 1'b1;
			pin_p2_out <= port2_func_reg_r & lcd_seg_drive | ~port2_func_reg_r & port2_latch_r;
			pin_p2_oe <= port2_func_reg_r | ~port2_mode_reg_r;
			pin_p2_seg_en <= port2_func_reg_r;
			pin_p2_analog_en <= p2_analog;
			for (int i = 0; i < P2_PINS; i++)
				adc_channel_active[i] <= p2_analog[i]
					&& (analog_channel_sel_r == 3'(i));
			// Debug use takes the main pins away from the oscillator
			main_osc_en <= clock_op_mode_reg_r[afps_pkg::CLK_X1]
				&& !clock_op_mode_reg_r[afps_pkg::CLK_EXT] && !debug_active;
			external_main_clock_en <= clock_op_mode_reg_r[afps_pkg::CLK_EXT]
				&& !debug_active;
			sub_osc_en <= clock_op_mode_reg_r[afps_pkg::CLK_XT1];
		end
	end

	a_capture_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(input_switch_ctrl_r[afps_pkg::ISC_CAP]) |-> timer_capture_in == uart_b_receive)
		else $error("capture source wrong");
	a_irq_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(input_switch_ctrl_r[afps_pkg::ISC_IRQ]) |-> ext_irq_zero == uart_b_receive)
		else $error("irq zero source wrong");
	a_gate_timer: assert property (@(posedge clk) disable iff (!rst_b)
		(input_switch_ctrl_r[afps_pkg::ISC_GATE] && !eight_bit_gate_timer)
		|=> !event_counter_enable)
		else $error("counter not gated");
	a_quarter_bias: assert property (@(posedge clk) disable iff (!rst_b)
		lcd_ref_voltage_four |-> key_input_zero)
		else $error("key zero active under quarter bias");
	a_route_p12: assert property (@(posedge clk) disable iff (!rst_b)
		route_p12 |=> uart_b_receive == $past(pin_f_r[afps_pkg::SP_P12]))
		else $error("serial-B receive not from port12");
	a_no_route: assert property (@(posedge clk) disable iff (!rst_b)
		!(route_p12 || route_p113) |=> uart_b_receive)
		else $error("unrouted receive not idle");
	a_clock_reset: assert property (@(posedge clk) disable iff (!rst_b)
		$past(clock_op_mode_reg_r) == afps_pkg::CLKM_RST
		|-> !main_osc_en && !external_main_clock_en && !sub_osc_en)
		else $error("oscillator enabled at mode 00H");
	a_debug_pins: assert property (@(posedge clk) disable iff (!rst_b)
		!debug_active [*2] |-> ##1 !debug_mode_pin_a && !debug_mode_pin_b)
		else $error("debug pins without debug");
	a_port2_seg: assert property (@(posedge clk) disable iff (!rst_b)
		(pin_p2_seg_en & pin_p2_analog_en) == '0)
		else $error("port2 pin both segment and analog");
	a_adc_onehot: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot0(adc_channel_active) && (adc_channel_active & ~pin_p2_analog_en) == '0)
		else $error("analog channel on non-analog pin");
	a_p13_mode: assert property (@(posedge clk) disable iff (!rst_b)
		p13_ctrl_r[afps_pkg::P13_MODE] |=> !pin_p13_oe)
		else $error("port13 driven in input mode");
	c_route_p12: cover property (@(posedge clk) disable iff (!rst_b) route_p12 ##1 !uart_b_receive);
	c_route_p113: cover property (@(posedge clk) disable iff (!rst_b) route_p113 ##1 !uart_b_receive);
	c_capture: cover property (@(posedge clk) disable iff (!rst_b)
		input_switch_ctrl_r[afps_pkg::ISC_CAP] ##1 !timer_capture_in);
	c_adc: cover property (@(posedge clk) disable iff (!rst_b) |adc_channel_active);
endmodule : afps_pin_select
`default_nettype wire

// ==== bench/afps_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module afps_pin_model (
	input wire logic [7:0] pin_lvl,
	input wire logic pin_p13_out,
	input wire logic pin_p13_oe,
	output logic pin_p12_in,
	output logic pin_p13_in,
	output logic pin_p33_in,
	output logic pin_p120_in,
	output logic pin_p113_in,
	output logic pin_p40_in,
	output logic pin_p121_in,
	output logic pin_p122_in
);
	// Shared port13 wire: device drive wins while enabled
	assign pin_p13_in = pin_p13_oe ? pin_p13_out : pin_lvl[1];
	assign pin_p12_in = pin_lvl[0];
	assign pin_p33_in = pin_lvl[2];
	assign pin_p120_in = pin_lvl[3];
	assign pin_p113_in = pin_lvl[4];
	assign pin_p40_in = pin_lvl[5];
	assign pin_p121_in = pin_lvl[6];
	assign pin_p122_in = pin_lvl[7];
endmodule : afps_pin_model
`default_nettype wire

// ==== bench/alt_function_pin_select_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module alt_function_pin_select_test;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, debug_active = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, pin_lvl = 8'hFF, reg_rdata;
	logic pin_p12_in, pin_p13_in, pin_p13_out, pin_p13_oe, pin_p33_in, pin_p120_in, pin_p113_in;
	logic pin_p112_out, pin_p112_oe, pin_p40_in, pin_p121_in, pin_p122_in;
	logic [5:0] pin_p2_out, pin_p2_oe, pin_p2_seg_en, pin_p2_analog_en, adc_channel_active;
	logic [5:0] lcd_seg_drive = 6'h15;
	logic uart_a_transmit = 1, uart_b_transmit = 0, csi_serial_out = 1, eight_bit_gate_timer = 0;
	logic uart_b_receive, timer_capture_in, ext_irq_zero, event_counter_enable, key_input_four;
	logic key_input_zero, lcd_ref_voltage_four, debug_mode_pin_a, debug_mode_pin_b;
	logic main_osc_en, external_main_clock_en, sub_osc_en;
	int mismatches = 0, n_tests = 0, cyc = 0;
	always #5 clk = ~clk;
	afps_pin_select dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin_p12_in, .pin_p13_in, .pin_p13_out, .pin_p13_oe, .pin_p33_in, .pin_p120_in,
		.pin_p113_in, .pin_p112_out, .pin_p112_oe, .pin_p40_in, .pin_p121_in, .pin_p122_in,
		.pin_p2_out, .pin_p2_oe, .pin_p2_seg_en, .pin_p2_analog_en, .adc_channel_active,
		.lcd_seg_drive, .uart_a_transmit, .uart_b_transmit, .csi_serial_out,
		.eight_bit_gate_timer, .debug_active, .uart_b_receive, .timer_capture_in,
		.ext_irq_zero, .event_counter_enable, .key_input_four, .key_input_zero,
		.lcd_ref_voltage_four, .debug_mode_pin_a, .debug_mode_pin_b, .main_osc_en,
		.external_main_clock_en, .sub_osc_en);
	afps_pin_model pins_u (.pin_lvl, .pin_p13_out, .pin_p13_oe, .pin_p12_in, .pin_p13_in,
		.pin_p33_in, .pin_p120_in, .pin_p113_in, .pin_p40_in, .pin_p121_in, .pin_p122_in);
	task summarize();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		settle(2);
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
		settle(1);
		chk(reg_rdata, 8'h00);
	endtask : rd
	task pins(input logic [7:0] v);
		@(posedge clk);
		pin_lvl <= v;
		settle(6);
	endtask : pins
	task t_regs();
		rd(4'h7, 8'h00);
		chk(main_osc_en | sub_osc_en | external_main_clock_en, 8'h00);
		rd(4'h4, 8'h3F);
		rd(4'h1, 8'h02);
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'h3F);
		rd(4'hF, 8'h00);
	endtask : t_regs
	task t_route();
		wr(4'h0, 8'h20);
		pins(8'hFE);
		chk(uart_b_receive, 8'h00);
		chk(ext_irq_zero, 8'h01);
		chk(timer_capture_in, 8'h01);
		wr(4'h0, 8'h23);
		chk(timer_capture_in, 8'h00);
		chk(ext_irq_zero, 8'h00);
		wr(4'h0, 8'h30);
		chk(uart_b_receive, 8'h01);
		wr(4'h0, 8'h08);
		pins(8'hEF);
		chk(uart_b_receive, 8'h00);
		chk(pin_p112_out, 8'h00);
		wr(4'h0, 8'h00);
		chk({pin_p112_oe, pin_p112_out, uart_b_receive}, 8'h07);
	endtask : t_route
	task t_gate();
		wr(4'h0, 8'h04);
		chk(event_counter_enable, 8'h00);
		@(posedge clk);
		eight_bit_gate_timer <= 1'b1;
		settle(2);
		chk(event_counter_enable, 8'h01);
	endtask : t_gate
	task t_lcd();
		pins(8'hDF);
		chk({lcd_ref_voltage_four, key_input_zero}, 8'h00);
		wr(4'h8, 8'h01);
		chk({lcd_ref_voltage_four, key_input_zero}, 8'h03);
		wr(4'h8, 8'h00);
	endtask : t_lcd
	task t_p13();
		wr(4'h1, 8'h01);
		wr(4'h0, 8'h20);
		chk({pin_p13_oe, pin_p13_out}, 8'h02);
		wr(4'h0, 8'h00);
		chk({pin_p13_oe, pin_p13_out}, 8'h03);
		wr(4'h1, 8'h02);
		pins(8'hFD);
		chk({pin_p13_oe, key_input_four}, 8'h00);
		rd(4'h9, 8'hFD);
	endtask : t_p13
	task t_clk();
		wr(4'h7, 8'h01);
		chk(main_osc_en, 8'h01);
		wr(4'h7, 8'h12);
		chk({external_main_clock_en, sub_osc_en}, 8'h03);
		wr(4'h7, 8'h01);
		@(posedge clk);
		debug_active <= 1'b1;
		settle(2);
		chk({main_osc_en, debug_mode_pin_a, debug_mode_pin_b}, 8'h03);
		@(posedge clk);
		debug_active <= 1'b0;
		settle(2);
		chk({main_osc_en, debug_mode_pin_a, debug_mode_pin_b}, 8'h04);
	endtask : t_clk
	task t_p2();
		wr(4'h3, 8'h3F);
		wr(4'h6, 8'h02);
		chk(pin_p2_analog_en, 8'h3F);
		chk(pin_p2_oe, 8'h00);
		chk(adc_channel_active, 8'h04);
		wr(4'h2, 8'h3F);
		chk(pin_p2_seg_en, 8'h3F);
		chk(pin_p2_analog_en, 8'h00);
		chk(pin_p2_out, 8'h15);
		wr(4'h2, 8'h00);
		wr(4'h4, 8'h0F);
		wr(4'h5, 8'h2A);
		chk(pin_p2_oe, 8'h30);
		chk(pin_p2_out, 8'h2A);
		chk(pin_p2_analog_en, 8'h0F);
	endtask : t_p2
	initial
	begin
		settle(10);
		chk({uart_b_receive, timer_capture_in, ext_irq_zero, lcd_ref_voltage_four}, 8'h0E);
		chk({main_osc_en, debug_mode_pin_a, debug_mode_pin_b}, 8'h00);
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		settle(8);
		t_regs();
		t_route();
		t_gate();
		t_lcd();
		t_p13();
		t_clk();
		t_p2();
		summarize();
	end
endmodule : alt_function_pin_select_test
`default_nettype wire
